// >>> gdf_pkg.sv
// package for the grouped input debounce filter
// assumes a 20 MHz clock; shared by the filter top and its channel module
package gdf_pkg;
   // clock period in nanoseconds
   localparam int CLK_PERIOD_NS = 50;
   // nominal detection times in microseconds, per setting code
   localparam int T0_US = 150;
   localparam int T1_US = 1000;
   localparam int T2_US = 5000;
   localparam int T3_US = 10000;
   // cycle counts derived from times (least time, rounded up)
   localparam int CYC0 = (T0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC1 = (T1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC2 = (T2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC3 = (T3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // counter width big enough for the longest count
   localparam int CNT_W = 18;
   // input count and group boundaries
   localparam int N_IN = 12;
   localparam int G1_LO = 0;
   localparam int G2_LO = 2;
   localparam int G3_LO = 10;
   // setting code encoding
   typedef enum logic [1:0]
   {
      GDF_SET_0MS = 2'h0,
      GDF_SET_1MS = 2'h1,
      GDF_SET_5MS = 2'h2,
      GDF_SET_10MS = 2'h3
   } gdf_set_t;
   // settings for all three groups, group 1 first
   typedef struct packed
   {
      gdf_set_t g1;
      gdf_set_t g2;
      gdf_set_t g3;
   } gdf_cfg_t;
   // reset value of the settings
   localparam gdf_cfg_t CFG_RST = '{GDF_SET_0MS, GDF_SET_0MS, GDF_SET_0MS};
endpackage

// >>> gdf_chan.sv
// one debounce channel: holds accepted level until raw level is stable
// assumes raw input synchronous to clk and a cycle threshold from the top
module gdf_chan #(
   parameter int CNT_W = gdf_pkg::CNT_W
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic raw,
   input wire logic [CNT_W-1:0] thresh,
   output logic filt
);
   // run length of the differing level
   logic [CNT_W-1:0] cnt_r;

   // count cycles the raw level differs from the accepted one
   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_r <= '0;
      else if (raw == filt)
         cnt_r <= '0;
      else if (cnt_r < thresh)
         cnt_r <= cnt_r + 1'h1;
   end

   // accept the new level after an unbroken run
   always_ff @(posedge clk)
   begin
      if (srst)
         filt <= 1'h0;
      else if (raw != filt && cnt_r + 1'h1 >= thresh)
         filt <= raw;
   end
endmodule

// >>> gdf_top.sv
// grouped input debounce filter with console setting port
// assumes console handshakes are one-cycle strobes synchronous to clk
module gdf_top #(
   parameter int N_IN = gdf_pkg::N_IN,
   parameter int CNT_W = gdf_pkg::CNT_W
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic [N_IN-1:0] in_raw,
   output logic [N_IN-1:0] in_filt,
   input wire logic prog_mode,
   input wire logic cfg_wr,
   input wire gdf_pkg::gdf_cfg_t cfg_wdata,
   output logic cfg_wr_ack,
   output logic cfg_wr_err,
   input wire logic cfg_rd,
   output gdf_pkg::gdf_cfg_t cfg_rdata,
   output logic cfg_rd_vld
);
   // stored settings for the three groups
   gdf_pkg::gdf_cfg_t cfg_r;
   // write strobe taken in program mode
   logic wr_take;
   // write strobe refused while running
   logic wr_refuse;
   // group one threshold, inputs 0 and 1
   logic [CNT_W-1:0] th_g1;
   // group two threshold, inputs 2 to 9
   logic [CNT_W-1:0] th_g2;
   // group three threshold, inputs 10 and 11
   logic [CNT_W-1:0] th_g3;
   // per-input threshold, picked by group
   logic [CNT_W-1:0] th_in [N_IN];

   // map a setting code to a cycle count
   // counts sit at the short end of each allowed window
   // a longer count would still pass, but chatter gets through less
   // a two-bit code has no spare value; the default only keeps it latch free
   function automatic logic [CNT_W-1:0] code_cycles(input gdf_pkg::gdf_set_t c);
      case (c)
         // code 0: shortest detection time
         gdf_pkg::GDF_SET_0MS:
         begin
            code_cycles = CNT_W'(gdf_pkg::CYC0);
         end
         // code 1: one millisecond
         gdf_pkg::GDF_SET_1MS:
         begin
            code_cycles = CNT_W'(gdf_pkg::CYC1);
         end
         // code 2: five milliseconds
         gdf_pkg::GDF_SET_5MS:
         begin
            code_cycles = CNT_W'(gdf_pkg::CYC2);
         end
         // code 3: ten milliseconds, inside the half millisecond slack
         gdf_pkg::GDF_SET_10MS:
         begin
            code_cycles = CNT_W'(gdf_pkg::CYC3);
         end
         // not reachable
         default:
         begin
            code_cycles = CNT_W'(gdf_pkg::CYC0);
         end
      endcase
   endfunction

   // split the write strobe by mode
   // a refused write leaves the settings alone
   always_comb
   begin
      wr_take = cfg_wr && prog_mode;
      wr_refuse = cfg_wr && !prog_mode;
   end

   // settings store: whole word, program mode only
   // all three groups land on one edge, so the channels never
   // see a partly written set
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // start from the shortest filter
         cfg_r <= gdf_pkg::CFG_RST;
      end
      else if (wr_take)
      begin
         // whole word replaces the old settings
         cfg_r <= cfg_wdata;
      end
   end

   // write acknowledge, one cycle after the strobe
   // the console takes its own copy on this pulse,
   // so both copies change together
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // no answer pending after reset
         cfg_wr_ack <= 1'h0;
      end
      else
      begin
         // one pulse per accepted strobe
         cfg_wr_ack <= wr_take;
      end
   end

   // write refusal, one cycle after the strobe
   // tells the console its copy must stay as it was
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // no refusal pending after reset
         cfg_wr_err <= 1'h0;
      end
      else
      begin
         // one pulse per strobe in run mode
         cfg_wr_err <= wr_refuse;
      end
   end

   // read valid, one cycle after the strobe
   // reads are honoured in either mode
   // back to back reads give back to back pulses
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // no read pending after reset
         cfg_rd_vld <= 1'h0;
      end
      else
      begin
         // follows the read strobe
         cfg_rd_vld <= cfg_rd;
      end
   end

   // read data, all three groups in group order
   // holds until the next read, so a slow console can take it late
   // a read on the same edge as a write returns the old settings
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cfg_rdata <= gdf_pkg::CFG_RST;
      end
      else if (cfg_rd)
      begin
         // snapshot of the whole settings word
         cfg_rdata <= cfg_r;
      end
   end

   // group thresholds
   // recomputed from the stored codes every cycle, so a new setting
   // takes effect on the cycle after the write
   always_comb
   begin
      // group one
      th_g1 = code_cycles(cfg_r.g1);
      // group two
      th_g2 = code_cycles(cfg_r.g2);
      // group three
      th_g3 = code_cycles(cfg_r.g3);
   end

   // assign each input its group threshold and channel
   // group bounds come from the package, so another grouping
   // only changes the constants
   genvar i;
   generate
      for (i = 0; i < N_IN; i++)
      begin : g_ch
         // inputs 10 and 11
         if (i >= gdf_pkg::G3_LO)
         begin : g3
            assign th_in[i] = th_g3;
         end
         // inputs 2 to 9
         else if (i >= gdf_pkg::G2_LO)
         begin : g2
            assign th_in[i] = th_g2;
         end
         // inputs 0 and 1
         else
         begin : g1
            assign th_in[i] = th_g1;
         end
         // one debounce channel per input
         // each channel restarts its count on any return to the old level
         // and channels share nothing but their group threshold
         gdf_chan #(.CNT_W(CNT_W)) u_ch (
            .clk(clk),
            .srst(srst),
            .raw(in_raw[i]),
            .thresh(th_in[i]),
            .filt(in_filt[i])
         );
      end
   endgenerate
endmodule

// >>> gdf_checker.sv
// port assertions for the filter top
// bound into every gdf_top instance
module gdf_checker #(parameter int N_IN = 12)(
   input wire logic clk,
   input wire logic srst,
   input wire logic [N_IN-1:0] in_raw,
   input wire logic [N_IN-1:0] in_filt,
   input wire logic prog_mode,
   input wire logic cfg_wr,
   input wire gdf_pkg::gdf_cfg_t cfg_wdata,
   input wire logic cfg_wr_ack,
   input wire logic cfg_wr_err,
   input wire logic cfg_rd,
   input wire gdf_pkg::gdf_cfg_t cfg_rdata,
   input wire logic cfg_rd_vld
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wr_ack_a: assert property (cfg_wr && prog_mode |=> cfg_wr_ack && !cfg_wr_err) else $error("ack");
   wr_err_a: assert property (cfg_wr && !prog_mode |=> cfg_wr_err && !cfg_wr_ack) else $error("err");
   ack_cause_a: assert property (cfg_wr_ack || cfg_wr_err |-> $past(cfg_wr)) else $error("cause");
   rd_vld_a: assert property (cfg_rd |=> cfg_rd_vld) else $error("vld");
   rd_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata)) else $error("hold");
   wr_rd_a: assert property (cfg_wr && prog_mode ##1 !cfg_wr ##1 cfg_rd
      |=> cfg_rdata == $past(cfg_wdata, 3)) else $error("readback");
   filt_src_a: assert property (in_filt != $past(in_filt) |->
      (($past(in_raw) ^ in_filt) & (in_filt ^ $past(in_filt))) == '0) else $error("src");
   min_dur_a: assert property ($changed(in_filt[0]) |->
      $past(in_raw[0], 8) == in_filt[0]) else $error("short");
endmodule
bind gdf_top gdf_checker #(.N_IN(N_IN)) chk(.*);

// >>> gdf_con.sv
// console model: whole-word setting writes, reads
// assumes answers one cycle after each strobe
module gdf_con(
   input wire logic clk,
   input wire logic cfg_wr_ack,
   output logic cfg_wr,
   output logic cfg_rd,
   output gdf_pkg::gdf_cfg_t cfg_wdata,
   output gdf_pkg::gdf_cfg_t copy
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {cfg_wr, cfg_rd, cfg_wdata, copy} = '0;
   // all groups in one strobe, then released whole
   task automatic wr(input gdf_pkg::gdf_cfg_t d);
      @(negedge clk) {cfg_wr, cfg_wdata} = {1'h1, d};
      @(negedge clk) {cfg_wr, cfg_wdata} = {1'h0, ~d};
      if (cfg_wr_ack === 1'h1) copy = d;
   endtask
   task automatic rd();
      @(negedge clk) cfg_rd = 1'h1;
      @(negedge clk) cfg_rd = 1'h0;
   endtask
endmodule

// >>> tb_top.sv
// bench top: filter, console model, field inputs
// assumes code 0 and 1 take 3000 and 20000 cycles
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, srst = 1'h1, prog_mode = 1'h0, cfg_wr, cfg_rd, cfg_wr_ack, cfg_wr_err;
   logic cfg_rd_vld;
   logic [11:0] in_raw = 12'h000, in_filt;
   gdf_pkg::gdf_cfg_t cfg_wdata, cfg_rdata, copy, c;
   int mismatches = 0, tests_run = 0, cyc = 0;
   always #25 clk = ~clk;
   gdf_top dut(.*);
   gdf_con con(.*);
   // compare and count
   task automatic chk(input logic [11:0] e, input logic [11:0] g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic run(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic stop_test();
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // cycle ceiling
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         mismatches++;
         stop_test();
      end
   end
   initial
   begin
      run(2);
      srst = 1'h0;
      chk(12'h000, in_filt);
      prog_mode = 1'h1;
      for (int i = 0; i < 4; i++)
      begin
         c = {2'(i), 2'(3 - i), 2'h1};
         con.wr(c);
         con.rd();
         chk({6'h00, c}, {6'h00, cfg_rdata});
         chk({6'h00, c}, {6'h00, copy});
      end
      con.wr(6'h04);
      in_raw = 12'hFFF;
      run(2999);
      in_raw = 12'h000;
      run(5);
      chk(12'h000, in_filt);
      in_raw = 12'hFFF;
      run(2999);
      chk(12'h000, in_filt);
      run(1);
      chk(12'hC03, in_filt);
      run(16999);
      chk(12'hC03, in_filt);
      run(1);
      chk(12'hFFF, in_filt);
      prog_mode = 1'h0;
      con.wr(6'h3F);
      chk(12'h001, {11'h000, cfg_wr_err});
      chk(12'h004, {6'h00, copy});
      con.rd();
      chk(12'h004, {6'h00, cfg_rdata});
      chk(12'h001, {11'h000, cfg_rd_vld});
      stop_test();
   end
endmodule
